// file: rtl/cfrc_pkg.sv
package cfrc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_OC_FAULT = 8'h46;
    localparam logic [7:0] ADDR_OT_FAULT = 8'h4f;
    localparam logic [7:0] ADDR_OT_WARN = 8'h51;
    localparam logic [7:0] ADDR_PCT_LIMITS = 8'hd7;
    localparam logic [7:0] ADDR_RESPONSE = 8'he0;
    localparam logic [7:0] ADDR_MASK = 8'he1;
    localparam logic [7:0] ADDR_STATUS = 8'he2;
    localparam logic [7:0] ADDR_STATE = 8'he3;
    localparam logic [7:0] ADDR_RISE = 8'he4;

    // ****************************************
    // response field layout and codes
    // ****************************************
    localparam logic [1:0] RESP_LATCH = 2'h0;
    localparam logic [1:0] RESP_RESTART = 2'h1;
    localparam int RESP_OT_LSB = 0;
    localparam int RESP_OC_LSB = 2;
    localparam int RESP_OV_LSB = 4;
    localparam int RESP_UV_LSB = 6;
    localparam int RESP_BG_LSB = 8;
    localparam int RESP_OV_LS_SEL = 10;
    localparam int RESP_W = 11;

    // ****************************************
    // status bits
    // ****************************************
    localparam int ST_OT_FAULT = 0;
    localparam int ST_OT_WARN = 1;
    localparam int ST_BG_OT = 2;
    localparam int ST_LS_OC = 3;
    localparam int ST_HS_OC = 4;
    localparam int ST_OC_WARN = 5;
    localparam int ST_OV_FAULT = 6;
    localparam int ST_OV_WARN = 7;
    localparam int ST_UV_FAULT = 8;
    localparam int NUM_STATUS = 9;

    // ****************************************
    // comparator input positions
    // ****************************************
    localparam int IN_LS_OC = 0;
    localparam int IN_HS_OC = 1;
    localparam int IN_OC_WARN = 2;
    localparam int IN_OV_FAULT = 3;
    localparam int IN_OV_WARN = 4;
    localparam int IN_UV_FAULT = 5;
    localparam int IN_UV_WARN = 6;
    localparam int IN_FB_LOW = 7;
    localparam int IN_BG_OT = 8;
    localparam int IN_ENABLE = 9;
    localparam int NUM_IN = 10;

    // ****************************************
    // counts and reset values
    // ****************************************
    localparam logic [1:0] OC_TRIP_COUNT = 2'h3;
    localparam logic [18:0] RESTART_MULT = 19'h00007;
    localparam logic [16:0] OT_HYST_C = 17'h00014;
    localparam logic [RESP_W-1:0] RESP_RESET = 11'h156;
    localparam logic [15:0] OT_FAULT_RESET = 16'h0078;
    localparam logic [15:0] OT_WARN_RESET = 16'h0069;
    localparam logic [15:0] OC_FAULT_RESET = 16'h0020;
    localparam logic [7:0] PCT_RESET = 8'h00;
    localparam logic [15:0] RISE_RESET = 16'h0040;

    typedef enum logic [6:0] {
        ST_OFF = 7'b0000001,
        ST_SOFTSTART = 7'b0000010,
        ST_RUN = 7'b0000100,
        ST_HICCUP = 7'b0001000,
        ST_COOL = 7'b0010000,
        ST_OVDIS = 7'b0100000,
        ST_LATCHED = 7'b1000000
    } cfrc_state_e;

    typedef struct packed {
        cfrc_state_e state;
        logic [18:0] cnt;
        logic [1:0] ocCnt;
        logic ocSeenLs;
        logic ocSeenHs;
        logic coolBg;
        logic discharged;
        logic [NUM_IN-1:0] sync1;
        logic [NUM_IN-1:0] sync2;
        logic [15:0] ocThr;
        logic [15:0] otThr;
        logic [15:0] otWarnThr;
        logic [7:0] pctLimits;
        logic [RESP_W-1:0] resp;
        logic [NUM_STATUS-1:0] mask;
        logic [NUM_STATUS-1:0] status;
        logic [15:0] rise;
        logic [15:0] readData;
        logic pwmEn;
        logic hsOff;
        logic lsOn;
        logic pgLow;
        logic alert;
        logic cycleTerm;
    } cfrc_regs_s;
endpackage

// file: rtl/cfrc_fault_ctrl.sv
`timescale 1ns/1ns
module cfrc_fault_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // command register port
    input wire logic regWrite,
    input wire logic [7:0] regWriteAddr,
    input wire logic [15:0] regWriteData,
    input wire logic [7:0] regReadAddr,
    output logic [15:0] regReadData,
    // converter timing and telemetry
    input wire logic pwmTick,
    input wire logic [15:0] dieTemp,
    // analog comparators and enable pin
    input wire logic lowSideOcRaw,
    input wire logic highSideOcRaw,
    input wire logic ocWarnRaw,
    input wire logic ovFaultRaw,
    input wire logic ovWarnRaw,
    input wire logic uvFaultRaw,
    input wire logic uvWarnRaw,
    input wire logic feedbackLowRaw,
    input wire logic bandgapOtRaw,
    input wire logic converterEnableRaw,
    // switch driver control
    output logic pwmEnable,
    output logic highSideOff,
    output logic lowSideOn,
    output logic cycleTerminate,
    // power good and alert
    output logic powerGoodOut,
    output logic powerGoodOe,
    output logic smbAlert,
    // thresholds to the sense circuits
    output logic [15:0] ocThreshold,
    output logic [7:0] windowLimits
);
    cfrc_pkg::cfrc_regs_s r;
    cfrc_pkg::cfrc_regs_s n;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic ignored(input logic [1:0] code);
        ignored = (code != cfrc_pkg::RESP_LATCH) && (code != cfrc_pkg::RESP_RESTART);
    endfunction

    localparam int NUM_IN_W = cfrc_pkg::NUM_IN;
    logic [NUM_IN_W-1:0] rawIn;
    logic [cfrc_pkg::NUM_IN-1:0] s;
    logic [1:0] otResp, ocResp, ovResp, uvResp;
    logic otFaultHit, otWarnHit, coolEnough, ocNow, ocTrip, converting;
    logic [18:0] hiccupLimit;
    logic [cfrc_pkg::NUM_STATUS-1:0] ev;
    logic good;

    assign rawIn = {converterEnableRaw, bandgapOtRaw, feedbackLowRaw, uvWarnRaw, uvFaultRaw,
                    ovWarnRaw, ovFaultRaw, ocWarnRaw, highSideOcRaw, lowSideOcRaw};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = r;
        s = r.sync2;
        otResp = r.resp[cfrc_pkg::RESP_OT_LSB +: 2];
        ocResp = r.resp[cfrc_pkg::RESP_OC_LSB +: 2];
        ovResp = r.resp[cfrc_pkg::RESP_OV_LSB +: 2];
        uvResp = r.resp[cfrc_pkg::RESP_UV_LSB +: 2];
        otFaultHit = dieTemp > r.otThr;
        otWarnHit = dieTemp > r.otWarnThr;
        coolEnough = ({1'b0, dieTemp} + cfrc_pkg::OT_HYST_C) <= {1'b0, r.otThr};
        hiccupLimit = 19'(r.rise) * cfrc_pkg::RESTART_MULT;
        converting = (r.state == cfrc_pkg::ST_SOFTSTART) || (r.state == cfrc_pkg::ST_RUN);
        n.sync1 = rawIn;
        n.sync2 = r.sync1;

        // consecutive overcurrent counting, high or low side, one step per PWM count
        ocNow = s[cfrc_pkg::IN_LS_OC] | s[cfrc_pkg::IN_HS_OC];
        ocTrip = 1'b0;
        n.ocSeenLs = r.ocSeenLs | s[cfrc_pkg::IN_LS_OC];
        n.ocSeenHs = r.ocSeenHs | s[cfrc_pkg::IN_HS_OC];
        if (!converting) begin
            n.ocCnt = 2'h0;
            n.ocSeenLs = 1'b0;
            n.ocSeenHs = 1'b0;
        end else if (pwmTick) begin
            n.ocSeenLs = 1'b0;
            n.ocSeenHs = 1'b0;
            if (r.ocSeenLs | r.ocSeenHs | ocNow) begin
                ocTrip = (r.ocCnt == cfrc_pkg::OC_TRIP_COUNT - 2'h1);
                n.ocCnt = (r.ocCnt == cfrc_pkg::OC_TRIP_COUNT) ? r.ocCnt : r.ocCnt + 2'h1;
            end else begin
                n.ocCnt = 2'h0;
            end
        end

        // events feeding the sticky status
        ev = '0;
        ev[cfrc_pkg::ST_OT_FAULT] = otFaultHit;
        ev[cfrc_pkg::ST_OT_WARN] = otWarnHit;
        ev[cfrc_pkg::ST_BG_OT] = s[cfrc_pkg::IN_BG_OT];
        ev[cfrc_pkg::ST_LS_OC] = ocTrip & (r.ocSeenLs | s[cfrc_pkg::IN_LS_OC]);
        ev[cfrc_pkg::ST_HS_OC] = ocTrip & (r.ocSeenHs | s[cfrc_pkg::IN_HS_OC]);
        ev[cfrc_pkg::ST_OC_WARN] = s[cfrc_pkg::IN_OC_WARN];
        ev[cfrc_pkg::ST_OV_FAULT] = s[cfrc_pkg::IN_OV_FAULT];
        ev[cfrc_pkg::ST_OV_WARN] = s[cfrc_pkg::IN_OV_WARN];
        ev[cfrc_pkg::ST_UV_FAULT] = s[cfrc_pkg::IN_UV_FAULT] & (r.state == cfrc_pkg::ST_RUN);

        // register writes; write-one-to-clear on status
        if (regWrite) begin
            case (regWriteAddr)
                cfrc_pkg::ADDR_OC_FAULT: n.ocThr = regWriteData;
                cfrc_pkg::ADDR_OT_FAULT: n.otThr = regWriteData;
                cfrc_pkg::ADDR_OT_WARN: n.otWarnThr = regWriteData;
                cfrc_pkg::ADDR_PCT_LIMITS: n.pctLimits = regWriteData[7:0];
                cfrc_pkg::ADDR_RESPONSE: n.resp = regWriteData[cfrc_pkg::RESP_W-1:0];
                cfrc_pkg::ADDR_MASK: n.mask = regWriteData[cfrc_pkg::NUM_STATUS-1:0];
                cfrc_pkg::ADDR_STATUS: n.status = r.status & ~regWriteData[cfrc_pkg::NUM_STATUS-1:0];
                cfrc_pkg::ADDR_RISE: n.rise = regWriteData;
                default: n.status = n.status;
            endcase
        end
        // a new event in the clearing cycle survives
        n.status = n.status | ev;

        // ****************************************
        // response sequencing
        // ****************************************
        case (r.state)
            cfrc_pkg::ST_OFF: begin
                if (s[cfrc_pkg::IN_ENABLE]) begin
                    n.state = cfrc_pkg::ST_SOFTSTART;
                    n.cnt = '0;
                end
            end
            cfrc_pkg::ST_SOFTSTART, cfrc_pkg::ST_RUN: begin
                if (r.state == cfrc_pkg::ST_SOFTSTART && pwmTick) begin
                    if (r.cnt + 19'h1 >= 19'(r.rise)) begin
                        n.state = cfrc_pkg::ST_RUN;
                        n.cnt = '0;
                    end else begin
                        n.cnt = r.cnt + 19'h1;
                    end
                end
                if (s[cfrc_pkg::IN_BG_OT]) begin
                    n.state = cfrc_pkg::ST_COOL;
                    n.coolBg = 1'b1;
                end else if (otFaultHit && !ignored(otResp)) begin
                    n.state = (otResp == cfrc_pkg::RESP_LATCH) ? cfrc_pkg::ST_LATCHED : cfrc_pkg::ST_COOL;
                    n.coolBg = 1'b0;
                end else if (s[cfrc_pkg::IN_OV_FAULT] && !ignored(ovResp)) begin
                    n.state = cfrc_pkg::ST_OVDIS;
                    n.discharged = 1'b0;
                    n.cnt = '0;
                end else if (ocTrip && !ignored(ocResp)) begin
                    n.state = (ocResp == cfrc_pkg::RESP_LATCH) ? cfrc_pkg::ST_LATCHED : cfrc_pkg::ST_HICCUP;
                    n.cnt = '0;
                end else if (ev[cfrc_pkg::ST_UV_FAULT] && !ignored(uvResp)) begin
                    n.state = (uvResp == cfrc_pkg::RESP_LATCH) ? cfrc_pkg::ST_LATCHED : cfrc_pkg::ST_HICCUP;
                    n.cnt = '0;
                end
            end
            cfrc_pkg::ST_HICCUP: begin
                if (pwmTick) begin
                    if (r.cnt + 19'h1 >= hiccupLimit) begin
                        n.state = cfrc_pkg::ST_SOFTSTART;
                        n.cnt = '0;
                    end else begin
                        n.cnt = r.cnt + 19'h1;
                    end
                end
            end
            cfrc_pkg::ST_COOL: begin
                if (r.coolBg ? !s[cfrc_pkg::IN_BG_OT] : coolEnough) begin
                    n.state = cfrc_pkg::ST_SOFTSTART;
                    n.cnt = '0;
                end
            end
            cfrc_pkg::ST_OVDIS: begin
                if (s[cfrc_pkg::IN_FB_LOW]) begin
                    n.discharged = 1'b1;
                end
                // restart countdown only once the discharge action is settled
                if (ovResp == cfrc_pkg::RESP_RESTART && pwmTick
                    && (r.resp[cfrc_pkg::RESP_OV_LS_SEL] || r.discharged)) begin
                    if (r.cnt + 19'h1 >= hiccupLimit) begin
                        n.state = cfrc_pkg::ST_SOFTSTART;
                        n.cnt = '0;
                    end else begin
                        n.cnt = r.cnt + 19'h1;
                    end
                end
            end
            cfrc_pkg::ST_LATCHED: n.state = cfrc_pkg::ST_LATCHED;
            default: n.state = cfrc_pkg::ST_OFF;
        endcase
        if (!s[cfrc_pkg::IN_ENABLE]) begin
            n.state = cfrc_pkg::ST_OFF;
            n.cnt = '0;
        end

        // ****************************************
        // outputs from the next state
        // ****************************************
        n.pwmEn = (n.state == cfrc_pkg::ST_SOFTSTART) || (n.state == cfrc_pkg::ST_RUN);
        n.hsOff = !n.pwmEn;
        n.lsOn = (n.state == cfrc_pkg::ST_OVDIS) && (n.resp[cfrc_pkg::RESP_OV_LS_SEL] || !n.discharged);
        n.cycleTerm = s[cfrc_pkg::IN_HS_OC];
        good = (n.state == cfrc_pkg::ST_RUN)
            && !(otWarnHit && !ignored(otResp))
            && !(s[cfrc_pkg::IN_OC_WARN] && !ignored(ocResp))
            && !(s[cfrc_pkg::IN_OV_WARN] && !ignored(ovResp))
            && !(s[cfrc_pkg::IN_UV_WARN] && !ignored(uvResp));
        n.pgLow = !good;
        n.alert = |(n.status & ~n.mask);

        case (regReadAddr)
            cfrc_pkg::ADDR_OC_FAULT: n.readData = r.ocThr;
            cfrc_pkg::ADDR_OT_FAULT: n.readData = r.otThr;
            cfrc_pkg::ADDR_OT_WARN: n.readData = r.otWarnThr;
            cfrc_pkg::ADDR_PCT_LIMITS: n.readData = {8'h00, r.pctLimits};
            cfrc_pkg::ADDR_RESPONSE: n.readData = 16'(r.resp);
            cfrc_pkg::ADDR_MASK: n.readData = 16'(r.mask);
            cfrc_pkg::ADDR_STATUS: n.readData = 16'(r.status);
            cfrc_pkg::ADDR_STATE: n.readData = 16'(r.state);
            cfrc_pkg::ADDR_RISE: n.readData = r.rise;
            default: n.readData = 16'h0000;
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            r <= '0;
            r.state <= cfrc_pkg::ST_OFF;
            r.resp <= cfrc_pkg::RESP_RESET;
            r.otThr <= cfrc_pkg::OT_FAULT_RESET;
            r.otWarnThr <= cfrc_pkg::OT_WARN_RESET;
            r.ocThr <= cfrc_pkg::OC_FAULT_RESET;
            r.pctLimits <= cfrc_pkg::PCT_RESET;
            r.rise <= cfrc_pkg::RISE_RESET;
            r.hsOff <= 1'b1;
            r.pgLow <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign regReadData = r.readData;
    assign pwmEnable = r.pwmEn;
    assign highSideOff = r.hsOff;
    assign lowSideOn = r.lsOn;
    assign cycleTerminate = r.cycleTerm;
    assign powerGoodOut = 1'b0;
    assign powerGoodOe = r.pgLow;
    assign smbAlert = r.alert;
    assign ocThreshold = r.ocThr;
    assign windowLimits = r.pctLimits;
endmodule

// file: tb/cfrc_switch_model.sv
`timescale 1ns/1ns
// ****************************************
// switch stage and pwm counter model
// ****************************************
module cfrc_switch_model #(
    parameter int TICK_DIV = 8,
    parameter int DISCHARGE = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // switch controls
    input wire logic pwmEnable,
    input wire logic lowSideOn,
    // pwm count and feedback comparator
    output logic pwmTick,
    output logic feedbackLowRaw
);
    int divCnt;
    int dis;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            divCnt <= 0;
            dis <= 0;
        end else begin
            divCnt <= (divCnt + 1) % TICK_DIV;
            // output only sags while the low side pulls it; pwm recharges it
            if (pwmEnable) begin
                dis <= 0;
            end else if (lowSideOn && dis < DISCHARGE) begin
                dis <= dis + 1;
            end
        end
        pwmTick <= rstn && (divCnt == TICK_DIV - 1);
        feedbackLowRaw <= (dis >= DISCHARGE);
    end
endmodule

// file: tb/cfrc_fault_ctrl_asserts.sv
`timescale 1ns/1ns
// ****************************************
// port checks
// ****************************************
module cfrc_fault_ctrl_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // inputs of interest
    input wire logic regWrite,
    input wire logic [7:0] regWriteAddr,
    input wire logic [15:0] regWriteData,
    input wire logic highSideOcRaw,
    input wire logic ovFaultRaw,
    input wire logic bandgapOtRaw,
    input wire logic converterEnableRaw,
    // outputs watched
    input wire logic pwmEnable,
    input wire logic highSideOff,
    input wire logic lowSideOn,
    input wire logic cycleTerminate,
    input wire logic powerGoodOe,
    input wire logic smbAlert,
    input wire logic [15:0] ocThreshold
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    property p_hs_off; highSideOff == !pwmEnable; endproperty
    a_hs_off: assert property (p_hs_off)
        else $error("high side off is not the inverse of pwm enable");
    property p_pg_off; !pwmEnable |-> powerGoodOe; endproperty
    a_pg_off: assert property (p_pg_off)
        else $error("power good released with switches off");
    property p_ls_hs; lowSideOn |-> highSideOff && !pwmEnable; endproperty
    a_ls_hs: assert property (p_ls_hs)
        else $error("low side forced on while high side may switch");
    property p_cyc_term; $rose(highSideOcRaw) |-> ##[2:5] cycleTerminate; endproperty
    a_cyc_term: assert property (p_cyc_term)
        else $error("peak limit did not end the cycle");
    property p_en_off; !converterEnableRaw [*5] |-> !pwmEnable; endproperty
    a_en_off: assert property (p_en_off)
        else $error("switching while enable is low");
    property p_bg_off; bandgapOtRaw [*5] |-> !pwmEnable && powerGoodOe; endproperty
    a_bg_off: assert property (p_bg_off)
        else $error("switching while bandgap overtemperature is present");
    property p_mask_all;
        regWrite && regWriteAddr == cfrc_pkg::ADDR_MASK && regWriteData[8:0] == 9'h1ff |=> !smbAlert;
    endproperty
    a_mask_all: assert property (p_mask_all)
        else $error("alert raised with every source masked");
    property p_ov_cause;
        $rose(lowSideOn) |-> $past(ovFaultRaw, 3) || $past(ovFaultRaw, 4) || $past(ovFaultRaw, 5);
    endproperty
    a_ov_cause: assert property (p_ov_cause)
        else $error("low side forced on without overvoltage");
    property p_oc_thr;
        regWrite && regWriteAddr == cfrc_pkg::ADDR_OC_FAULT |=> ocThreshold == $past(regWriteData);
    endproperty
    a_oc_thr: assert property (p_oc_thr)
        else $error("overcurrent threshold not updated by write");
endmodule

bind cfrc_fault_ctrl cfrc_fault_ctrl_asserts i_cfrc_fault_ctrl_asserts (.sys_clk, .rstn, .regWrite,
    .regWriteAddr, .regWriteData, .highSideOcRaw, .ovFaultRaw, .bandgapOtRaw, .converterEnableRaw, .pwmEnable,
    .highSideOff, .lowSideOn, .cycleTerminate, .powerGoodOe, .smbAlert, .ocThreshold);

// file: tb/tb_cfrc_fault_ctrl.sv
`timescale 1ns/1ns
// ****************************************
// fault controller bench
// ****************************************
module tb_cfrc_fault_ctrl;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regWriteAddr = 8'h00;
    logic [15:0] regWriteData = 16'h0000;
    logic [7:0] regReadAddr = 8'h00;
    logic [15:0] dieTemp = 16'h0020;
    logic lowSideOcRaw = 1'b0, highSideOcRaw = 1'b0, ocWarnRaw = 1'b0, ovFaultRaw = 1'b0, ovWarnRaw = 1'b0;
    logic uvFaultRaw = 1'b0, uvWarnRaw = 1'b0, bandgapOtRaw = 1'b0, converterEnableRaw = 1'b0;
    logic pwmTick, feedbackLowRaw, pwmEnable, highSideOff, lowSideOn, cycleTerminate;
    logic powerGoodOut, powerGoodOe, smbAlert;
    logic [15:0] regReadData, ocThreshold;
    logic [7:0] windowLimits;
    int mismatches = 0;
    int comparisons = 0;
    cfrc_fault_ctrl i_cfrc_fault_ctrl (.sys_clk, .rstn, .regWrite, .regWriteAddr, .regWriteData, .regReadAddr,
        .regReadData, .pwmTick, .dieTemp, .lowSideOcRaw, .highSideOcRaw, .ocWarnRaw, .ovFaultRaw, .ovWarnRaw,
        .uvFaultRaw, .uvWarnRaw, .feedbackLowRaw, .bandgapOtRaw, .converterEnableRaw, .pwmEnable, .highSideOff,
        .lowSideOn, .cycleTerminate, .powerGoodOut, .powerGoodOe, .smbAlert, .ocThreshold, .windowLimits);
    cfrc_switch_model i_cfrc_switch_model (.sys_clk, .rstn, .pwmEnable, .lowSideOn, .pwmTick, .feedbackLowRaw);
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        regWrite = 1'b1;
        regWriteAddr = a;
        regWriteData = d;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge sys_clk);
        regReadAddr = a;
        @(negedge sys_clk);
        check(regReadData, exp);
    endtask
    task automatic st(input cfrc_pkg::cfrc_state_e s);
        rd(cfrc_pkg::ADDR_STATE, {9'h000, s});
    endtask
    task automatic pins(input logic pe, input logic pg);
        check({13'h0000, pwmEnable, powerGoodOe, powerGoodOut}, {13'h0000, pe, pg, 1'b0});
    endtask
    task automatic sides(input logic [15:0] exp);
        check({14'h0000, highSideOff, lowSideOn}, exp);
    endtask
    // a latched converter only leaves through the enable pin
    task automatic reen();
        converterEnableRaw = 1'b0;
        cyc(10);
        converterEnableRaw = 1'b1;
        cyc(40);
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        rd(cfrc_pkg::ADDR_RESPONSE, 16'h0156);
        rd(8'h00, 16'h0000);
        st(cfrc_pkg::ST_OFF);
        wr(cfrc_pkg::ADDR_OC_FAULT, 16'h0033);
        wr(cfrc_pkg::ADDR_PCT_LIMITS, 16'h01a5);
        check(ocThreshold, 16'h0033);
        check({8'h00, windowLimits}, 16'h00a5);
        rd(cfrc_pkg::ADDR_PCT_LIMITS, 16'h00a5);
        wr(cfrc_pkg::ADDR_RISE, 16'h0002);
        reen();
        wr(cfrc_pkg::ADDR_STATE, 16'h0040);
        st(cfrc_pkg::ST_RUN);
        dieTemp = 16'h0080;
        cyc(10);
        pins(1'b1, 1'b0);
        check({15'h0000, smbAlert}, 16'h0001);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0155);
        cyc(10);
        st(cfrc_pkg::ST_COOL);
        dieTemp = 16'h0065;
        cyc(20);
        st(cfrc_pkg::ST_COOL);
        pins(1'b0, 1'b1);
        dieTemp = 16'h0064;
        cyc(40);
        st(cfrc_pkg::ST_RUN);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0154);
        dieTemp = 16'h0080;
        cyc(10);
        st(cfrc_pkg::ST_LATCHED);
        dieTemp = 16'h0020;
        cyc(20);
        st(cfrc_pkg::ST_LATCHED);
        pins(1'b0, 1'b1);
        reen();
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0056);
        bandgapOtRaw = 1'b1;
        cyc(10);
        st(cfrc_pkg::ST_COOL);
        bandgapOtRaw = 1'b0;
        cyc(40);
        st(cfrc_pkg::ST_RUN);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0152);
        lowSideOcRaw = 1'b1;
        cyc(8);
        st(cfrc_pkg::ST_RUN);
        cyc(30);
        st(cfrc_pkg::ST_LATCHED);
        pins(1'b0, 1'b1);
        lowSideOcRaw = 1'b0;
        reen();
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0156);
        highSideOcRaw = 1'b1;
        cyc(40);
        st(cfrc_pkg::ST_HICCUP);
        highSideOcRaw = 1'b0;
        cyc(60);
        st(cfrc_pkg::ST_HICCUP);
        cyc(100);
        st(cfrc_pkg::ST_RUN);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h015e);
        highSideOcRaw = 1'b1;
        ocWarnRaw = 1'b1;
        cyc(40);
        st(cfrc_pkg::ST_RUN);
        pins(1'b1, 1'b0);
        check({15'h0000, cycleTerminate}, 16'h0001);
        highSideOcRaw = 1'b0;
        ocWarnRaw = 1'b0;
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0156);
        ovWarnRaw = 1'b1;
        cyc(10);
        pins(1'b1, 1'b1);
        ovWarnRaw = 1'b0;
        ovFaultRaw = 1'b1;
        cyc(10);
        st(cfrc_pkg::ST_OVDIS);
        sides(16'h0003);
        ovFaultRaw = 1'b0;
        cyc(30);
        sides(16'h0002);
        cyc(140);
        st(cfrc_pkg::ST_RUN);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0556);
        ovFaultRaw = 1'b1;
        cyc(10);
        ovFaultRaw = 1'b0;
        cyc(30);
        sides(16'h0003);
        cyc(140);
        st(cfrc_pkg::ST_RUN);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0176);
        ovFaultRaw = 1'b1;
        cyc(10);
        st(cfrc_pkg::ST_RUN);
        ovFaultRaw = 1'b0;
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0146);
        ovFaultRaw = 1'b1;
        cyc(10);
        ovFaultRaw = 1'b0;
        cyc(200);
        st(cfrc_pkg::ST_OVDIS);
        sides(16'h0002);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0156);
        wr(cfrc_pkg::ADDR_RISE, 16'h0010);
        converterEnableRaw = 1'b0;
        cyc(10);
        uvFaultRaw = 1'b1;
        converterEnableRaw = 1'b1;
        cyc(60);
        st(cfrc_pkg::ST_SOFTSTART);
        cyc(120);
        st(cfrc_pkg::ST_HICCUP);
        uvFaultRaw = 1'b0;
        cyc(1100);
        st(cfrc_pkg::ST_RUN);
        wr(cfrc_pkg::ADDR_RESPONSE, 16'h0116);
        uvFaultRaw = 1'b1;
        cyc(10);
        st(cfrc_pkg::ST_LATCHED);
        pins(1'b0, 1'b1);
        uvFaultRaw = 1'b0;
        dieTemp = 16'h0080;
        wr(cfrc_pkg::ADDR_MASK, 16'h01ff);
        check({15'h0000, smbAlert}, 16'h0000);
        wr(cfrc_pkg::ADDR_MASK, 16'h01fe);
        check({15'h0000, smbAlert}, 16'h0001);
        dieTemp = 16'h0020;
        cyc(4);
        wr(cfrc_pkg::ADDR_STATUS, 16'h01ff);
        rd(cfrc_pkg::ADDR_STATUS, 16'h0000);
        check({15'h0000, smbAlert}, 16'h0000);
        report_and_stop();
    end
endmodule
